// *** design/vcc_control_regs.sv ***
/*
  Control register bank of the voice codec: clock/format, path/channel,
  receive and transmit data bytes, audio routing and gains, decoded to
  configuration outputs. Assumes command bytes and PCM bytes come from
  same-clock logic, and the control-mode strap comes straight from a pin.
*/
module vcc_control_regs
  import vcc_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] CMD_BYTE_I,
  input wire logic CMD_VALID_I,
  input wire logic SEP_CTRL_MODE_I,
  input wire logic [7:0] PCM_RX_BYTE_I,
  input wire logic PCM_RX_STROBE_I,
  input wire logic [7:0] TX_PATH_BYTE_I,
  output logic [7:0] RDATA_O,
  output logic RDATA_VALID_O,
  output logic POWER_DOWN_O,
  output logic [1:0] CLOCK_RATE_SEL_O,
  output logic COMPANDING_LAW_SEL_O,
  output logic CODING_VARIANT_SEL_O,
  output logic PCM_TIMING_SEL_O,
  output logic SLOT_SPACING_SEL_O,
  output logic SLOT_WIDTH_SEL_O,
  output logic LOOPBACK_SEL_O,
  output logic HANDSFREE_PINS_EN_O,
  output logic ANTI_FEEDBACK_EN_O,
  output logic GENERAL_LATCH_OUT_O,
  output logic GENERAL_LATCH_OE_O,
  output logic RECEIVE_SOURCE_SEL_O,
  output logic TRANSMIT_SOURCE_SEL_O,
  output logic VOICE_XFER_EN_O,
  output logic [1:0] VOICE_CHANNEL_SEL_O,
  output logic MICROPHONE_SEL_O,
  output logic TRANSMIT_INPUT_EN_O,
  output logic SIDETONE_EN_O,
  output logic AUX_RING_ROUTE_EN_O,
  output logic TONE_TO_SPEAKER_O,
  output logic TONE_TO_EARPIECE_O,
  output logic RX_TO_SPEAKER_O,
  output logic RX_TO_EARPIECE_O,
  output logic [3:0] TX_GAIN_O,
  output logic [3:0] SIDETONE_GAIN_O,
  output logic [7:0] RX_PATH_BYTE_O,
  output logic [7:0] PCM_TX_BYTE_O
);
  typedef struct packed {
    logic [7:0] clock_format_control;
    logic [7:0] path_channel_control;
    logic [7:0] receive_data_byte;
    logic [7:0] transmit_data_byte;
    logic [7:0] audio_routing_control;
    logic [7:0] transmit_sidetone_gain;
    logic [7:0] rx_captured;
    logic [7:0] rdata;
    logic rvalid;
    logic pwr;
    logic [2:0] msync;
    logic sep;
    logic [7:0] rx_path;
    logic [7:0] tx_pcm;
  } vcc_regs_t;

  vcc_regs_t st_reg;
  vcc_regs_t st_next;
  vcc_cmd_if cmd ();

  logic rx_from_reg;
  logic tx_from_reg;

  vcc_cmd_parser u_parser (
    .clk_i(SYS_CLK_I),
    .rstn_i(RSTN_I),
    .byte_i(CMD_BYTE_I),
    .valid_i(CMD_VALID_I),
    .cmd(cmd.parser)
  );

  // Source selects honoured only with the separate control port
  assign rx_from_reg = st_reg.sep && st_reg.path_channel_control[PC_RXSRC_BIT];
  assign tx_from_reg = st_reg.sep && st_reg.path_channel_control[PC_TXSRC_BIT];

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    // Strap passes three stages; change taken when last two agree
    st_next.msync = {st_reg.msync[1:0], SEP_CTRL_MODE_I};
    if (st_reg.msync[2] == st_reg.msync[1]) begin
      st_next.sep = st_reg.msync[2];
    end
    if (cmd.pwr_upd) begin
      st_next.pwr = cmd.pwr;
    end
    if (cmd.wr) begin
      if (cmd.sel == SEL_CLOCK_FORMAT) begin
        st_next.clock_format_control = cmd.wdata;
      end else if (cmd.sel == SEL_PATH_CHANNEL) begin
        st_next.path_channel_control = cmd.wdata;
      end else if (cmd.sel == SEL_RECEIVE_DATA) begin
        st_next.receive_data_byte = cmd.wdata;
      end else if (cmd.sel == SEL_TRANSMIT_DATA) begin
        st_next.transmit_data_byte = cmd.wdata;
      end else if (cmd.sel == SEL_AUDIO_ROUTING) begin
        st_next.audio_routing_control = cmd.wdata;
      end else if (cmd.sel == SEL_GAIN) begin
        st_next.transmit_sidetone_gain = cmd.wdata;
      end
    end
    if (cmd.rd) begin
      st_next.rvalid = 1'b1;
      if (cmd.sel == SEL_CLOCK_FORMAT) begin
        st_next.rdata = st_reg.clock_format_control;
      end else if (cmd.sel == SEL_PATH_CHANNEL) begin
        st_next.rdata = st_reg.path_channel_control;
      end else if (cmd.sel == SEL_RECEIVE_DATA) begin
        st_next.rdata = st_reg.rx_captured;
      end else if (cmd.sel == SEL_AUDIO_ROUTING) begin
        st_next.rdata = st_reg.audio_routing_control;
      end else if (cmd.sel == SEL_GAIN) begin
        st_next.rdata = st_reg.transmit_sidetone_gain;
      end else begin
        // Write-only and absent registers answer zero
        st_next.rdata = REG_RST;
      end
    end
    if (PCM_RX_STROBE_I) begin
      st_next.rx_captured = PCM_RX_BYTE_I;
    end
    st_next.rx_path = rx_from_reg ? st_reg.receive_data_byte : st_reg.rx_captured;
    if (tx_from_reg) begin
      st_next.tx_pcm = st_reg.transmit_data_byte;
    end else if (st_reg.clock_format_control[CF_LOOP_BIT]) begin
      st_next.tx_pcm = st_reg.rx_captured;
    end else begin
      st_next.tx_pcm = TX_PATH_BYTE_I;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_reg <= '{clock_format_control: REG_RST, path_channel_control: REG_RST,
                 receive_data_byte: REG_RST, transmit_data_byte: REG_RST,
                 audio_routing_control: REG_RST, transmit_sidetone_gain: REG_RST,
                 rx_captured: REG_RST, rdata: REG_RST, rvalid: 1'b0, pwr: PWR_RST,
                 msync: SYNC_RST, sep: SEP_MODE_RST, rx_path: REG_RST,
                 tx_pcm: REG_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign RDATA_O = st_reg.rdata;
  assign RDATA_VALID_O = st_reg.rvalid;
  assign POWER_DOWN_O = st_reg.pwr;
  // Clock rate, timing and spacing only meaningful with the separate port
  assign CLOCK_RATE_SEL_O = st_reg.sep ?
    st_reg.clock_format_control[CF_CLK_MSB:CF_CLK_LSB] : CLK_RATE_DEFAULT;
  assign COMPANDING_LAW_SEL_O = st_reg.clock_format_control[CF_LAW_BIT];
  assign CODING_VARIANT_SEL_O = st_reg.clock_format_control[CF_VARIANT_BIT];
  assign PCM_TIMING_SEL_O = st_reg.sep && st_reg.clock_format_control[CF_TIMING_BIT];
  assign SLOT_SPACING_SEL_O = st_reg.sep && st_reg.clock_format_control[CF_SPACING_BIT];
  assign SLOT_WIDTH_SEL_O = st_reg.clock_format_control[CF_WIDTH_BIT];
  assign LOOPBACK_SEL_O = st_reg.clock_format_control[CF_LOOP_BIT];
  assign HANDSFREE_PINS_EN_O = st_reg.path_channel_control[PC_HF_BIT];
  assign ANTI_FEEDBACK_EN_O = st_reg.path_channel_control[PC_AFB_BIT];
  // Open-drain latch: pulls low when enabled, floats otherwise
  assign GENERAL_LATCH_OUT_O = 1'b0;
  assign GENERAL_LATCH_OE_O = st_reg.path_channel_control[PC_LATCH_BIT];
  assign RECEIVE_SOURCE_SEL_O = rx_from_reg;
  assign TRANSMIT_SOURCE_SEL_O = tx_from_reg;
  assign VOICE_XFER_EN_O = st_reg.path_channel_control[PC_VOICE_BIT];
  assign VOICE_CHANNEL_SEL_O = st_reg.sep ? CHAN_DEFAULT :
    st_reg.path_channel_control[PC_CHAN_MSB:PC_CHAN_LSB];
  assign MICROPHONE_SEL_O = st_reg.audio_routing_control[AR_MIC_BIT];
  assign TRANSMIT_INPUT_EN_O = st_reg.audio_routing_control[AR_TXIN_BIT];
  assign SIDETONE_EN_O = st_reg.audio_routing_control[AR_SIDE_BIT];
  assign AUX_RING_ROUTE_EN_O = st_reg.audio_routing_control[AR_AUX_BIT];
  assign TONE_TO_SPEAKER_O = st_reg.audio_routing_control[AR_TONE_SPK_BIT];
  assign TONE_TO_EARPIECE_O = st_reg.audio_routing_control[AR_TONE_EAR_BIT];
  assign RX_TO_SPEAKER_O = st_reg.audio_routing_control[AR_RX_SPK_BIT];
  assign RX_TO_EARPIECE_O = st_reg.audio_routing_control[AR_RX_EAR_BIT];
  assign TX_GAIN_O = st_reg.transmit_sidetone_gain[GN_TX_MSB:GN_TX_LSB];
  assign SIDETONE_GAIN_O = st_reg.transmit_sidetone_gain[GN_ST_MSB:GN_ST_LSB];
  assign RX_PATH_BYTE_O = st_reg.rx_path;
  assign PCM_TX_BYTE_O = st_reg.tx_pcm;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence s_cmd_write(logic [3:0] s);
    CMD_VALID_I && u_parser.st_reg.state == VCC_ST_DATA && cmd.sel == s;
  endsequence

  property p_cf_write_readback;
    s_cmd_write(SEL_CLOCK_FORMAT) |-> ##2
      (st_reg.clock_format_control == $past(CMD_BYTE_I, 2));
  endproperty
  a_cf_write_readback: assert property (p_cf_write_readback)
    else $error("clock format write not stored");

  property p_read_answer;
    cmd.rd |=> RDATA_VALID_O ##1 (!RDATA_VALID_O || $past(cmd.rd));
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer not one pulse");

  property p_valid_cause;
    RDATA_VALID_O |-> $past(cmd.rd);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("spurious read answer");

  property p_rd_gain;
    cmd.rd && cmd.sel == SEL_GAIN |=> RDATA_O == $past(st_reg.transmit_sidetone_gain);
  endproperty
  a_rd_gain: assert property (p_rd_gain) else $error("gain read-back wrong");

  property p_rd_rx;
    cmd.rd && cmd.sel == SEL_RECEIVE_DATA |=> RDATA_O == $past(st_reg.rx_captured);
  endproperty
  a_rd_rx: assert property (p_rd_rx) else $error("receive byte read wrong");

  property p_rx_capture;
    PCM_RX_STROBE_I |=> st_reg.rx_captured == $past(PCM_RX_BYTE_I);
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("PCM byte not captured");

  property p_rx_source;
    rx_from_reg |=> RX_PATH_BYTE_O == $past(st_reg.receive_data_byte);
  endproperty
  a_rx_source: assert property (p_rx_source) else $error("receive path source wrong");

  property p_tx_source;
    tx_from_reg |=> PCM_TX_BYTE_O == $past(st_reg.transmit_data_byte);
  endproperty
  a_tx_source: assert property (p_tx_source) else $error("transmit byte not sent");

  property p_loopback;
    !tx_from_reg && LOOPBACK_SEL_O |=> PCM_TX_BYTE_O == $past(st_reg.rx_captured);
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback not routed");

  property p_gci_fields;
    !st_reg.sep |-> CLOCK_RATE_SEL_O == CLK_RATE_DEFAULT && !PCM_TIMING_SEL_O
      && !SLOT_SPACING_SEL_O && !RECEIVE_SOURCE_SEL_O && !TRANSMIT_SOURCE_SEL_O;
  endproperty
  a_gci_fields: assert property (p_gci_fields) else $error("separate-only field leaked");

  property p_latch;
    GENERAL_LATCH_OE_O == st_reg.path_channel_control[PC_LATCH_BIT] && !GENERAL_LATCH_OUT_O;
  endproperty
  a_latch: assert property (p_latch) else $error("latch pin drive wrong");

  property p_power;
    cmd.pwr_upd |=> POWER_DOWN_O == $past(cmd.pwr);
  endproperty
  a_power: assert property (p_power) else $error("power bit not applied");

  sequence s_strap_agree;
    st_reg.msync[2] == st_reg.msync[1];
  endsequence

  property p_pc_write;
    s_cmd_write(SEL_PATH_CHANNEL) |-> ##2 st_reg.path_channel_control == $past(CMD_BYTE_I, 2);
  endproperty
  a_pc_write: assert property (p_pc_write) else $error("path write not stored");

  property p_ar_write;
    s_cmd_write(SEL_AUDIO_ROUTING) |-> ##2 st_reg.audio_routing_control == $past(CMD_BYTE_I, 2);
  endproperty
  a_ar_write: assert property (p_ar_write) else $error("routing write not stored");

  property p_gn_write;
    s_cmd_write(SEL_GAIN) |-> ##2 st_reg.transmit_sidetone_gain == $past(CMD_BYTE_I, 2);
  endproperty
  a_gn_write: assert property (p_gn_write) else $error("gain write not stored");

  property p_rxd_write;
    s_cmd_write(SEL_RECEIVE_DATA) |-> ##2 st_reg.receive_data_byte == $past(CMD_BYTE_I, 2);
  endproperty
  a_rxd_write: assert property (p_rxd_write) else $error("receive byte write lost");

  property p_txd_write;
    s_cmd_write(SEL_TRANSMIT_DATA) |-> ##2 st_reg.transmit_data_byte == $past(CMD_BYTE_I, 2);
  endproperty
  a_txd_write: assert property (p_txd_write) else $error("transmit byte write lost");

  property p_refused_write;
    cmd.wr && cmd.sel > SEL_GAIN |=> $stable(st_reg.clock_format_control)
      && $stable(st_reg.path_channel_control)
      && $stable(st_reg.audio_routing_control)
      && $stable(st_reg.transmit_sidetone_gain)
      && $stable(st_reg.receive_data_byte) && $stable(st_reg.transmit_data_byte);
  endproperty
  a_refused_write: assert property (p_refused_write) else $error("absent register written");

  property p_rd_wo;
    cmd.rd && (cmd.sel == SEL_TRANSMIT_DATA || cmd.sel > SEL_GAIN) |=> RDATA_O == REG_RST;
  endproperty
  a_rd_wo: assert property (p_rd_wo) else $error("write-only read not zero");

  property p_rd_cf;
    cmd.rd && cmd.sel == SEL_CLOCK_FORMAT |=> RDATA_O == $past(st_reg.clock_format_control);
  endproperty
  a_rd_cf: assert property (p_rd_cf) else $error("clock format read-back wrong");

  property p_rdata_hold;
    !cmd.rd |=> $stable(RDATA_O);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_rx_default;
    !rx_from_reg |=> RX_PATH_BYTE_O == $past(st_reg.rx_captured);
  endproperty
  a_rx_default: assert property (p_rx_default) else $error("receive path not from PCM");

  property p_tx_default;
    !tx_from_reg && !LOOPBACK_SEL_O |=> PCM_TX_BYTE_O == $past(TX_PATH_BYTE_I);
  endproperty
  a_tx_default: assert property (p_tx_default) else $error("transmit path not sent");

  property p_mode_sync;
    s_strap_agree |=> st_reg.sep == $past(st_reg.msync[2]);
  endproperty
  a_mode_sync: assert property (p_mode_sync) else $error("mode strap not taken");

  property p_mode_hold;
    st_reg.msync[2] != st_reg.msync[1] |=> $stable(st_reg.sep);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode taken too early");

  property p_power_hold;
    !cmd.pwr_upd |=> $stable(POWER_DOWN_O);
  endproperty
  a_power_hold: assert property (p_power_hold) else $error("power bit moved");
endmodule

// *** pkg/vcc_pkg.sv ***
/*
  Constants for the voice codec control register bank: address byte layout,
  register selectors, field positions and reset values.
  Assumes a serial front end that delivers whole command bytes, MSB first.
*/
package vcc_pkg;
  // Address byte layout
  localparam int ADDR_PWR_BIT = 7;
  localparam int ADDR_SEL_MSB = 6;
  localparam int ADDR_SEL_LSB = 3;
  localparam int ADDR_RD_BIT = 2;
  localparam int ADDR_MORE_BIT = 1;
  // Register selectors (address bits 6:3)
  localparam logic [3:0] SEL_CLOCK_FORMAT = 4'h0;
  localparam logic [3:0] SEL_PATH_CHANNEL = 4'h1;
  localparam logic [3:0] SEL_RECEIVE_DATA = 4'h2;
  localparam logic [3:0] SEL_TRANSMIT_DATA = 4'h3;
  localparam logic [3:0] SEL_AUDIO_ROUTING = 4'h4;
  localparam logic [3:0] SEL_GAIN = 4'h5;
  // Clock/format fields
  localparam int CF_CLK_MSB = 7;
  localparam int CF_CLK_LSB = 6;
  localparam int CF_LAW_BIT = 5;
  localparam int CF_VARIANT_BIT = 4;
  localparam int CF_TIMING_BIT = 3;
  localparam int CF_SPACING_BIT = 2;
  localparam int CF_WIDTH_BIT = 1;
  localparam int CF_LOOP_BIT = 0;
  // Path/channel fields
  localparam int PC_HF_BIT = 7;
  localparam int PC_AFB_BIT = 6;
  localparam int PC_LATCH_BIT = 5;
  localparam int PC_RXSRC_BIT = 4;
  localparam int PC_TXSRC_BIT = 3;
  localparam int PC_VOICE_BIT = 2;
  localparam int PC_CHAN_MSB = 1;
  localparam int PC_CHAN_LSB = 0;
  // Audio routing fields
  localparam int AR_MIC_BIT = 7;
  localparam int AR_TXIN_BIT = 6;
  localparam int AR_SIDE_BIT = 5;
  localparam int AR_AUX_BIT = 4;
  localparam int AR_TONE_SPK_BIT = 3;
  localparam int AR_TONE_EAR_BIT = 2;
  localparam int AR_RX_SPK_BIT = 1;
  localparam int AR_RX_EAR_BIT = 0;
  // Gain fields
  localparam int GN_TX_MSB = 7;
  localparam int GN_TX_LSB = 4;
  localparam int GN_ST_MSB = 3;
  localparam int GN_ST_LSB = 0;
  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] CLK_RATE_DEFAULT = 2'h0;
  localparam logic [1:0] CHAN_DEFAULT = 2'h0;
  localparam logic PWR_RST = 1'b0;
  localparam logic SEP_MODE_RST = 1'b1;
  localparam logic [2:0] SYNC_RST = 3'h7;
  typedef enum logic [1:0] {
    VCC_ST_ADDR = 2'b01,
    VCC_ST_DATA = 2'b10
  } vcc_state_t;
endpackage

// *** pkg/vcc_cmd_if.sv ***
/*
  Carrier between the command byte parser and the register bank.
  Assumes both ends run on the same clock; all signals are one-cycle pulses
  except sel, wdata and pwr, which stand until the next command.
*/
interface vcc_cmd_if;
  logic wr;
  logic rd;
  logic pwr_upd;
  logic pwr;
  logic [3:0] sel;
  logic [7:0] wdata;
  modport parser (output wr, rd, pwr_upd, pwr, sel, wdata);
  modport regs (input wr, rd, pwr_upd, pwr, sel, wdata);
endinterface

// *** design/vcc_cmd_parser.sv ***
/*
  Command byte parser: splits the byte stream into address and data bytes.
  Assumes bytes arrive from a same-clock serial front end, one per strobe.
*/
module vcc_cmd_parser
  import vcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] byte_i,
  input wire logic valid_i,
  vcc_cmd_if.parser cmd
);
  typedef struct packed {
    vcc_state_t state;
    logic wr;
    logic rd;
    logic pwr_upd;
    logic pwr;
    logic [3:0] sel;
    logic [7:0] wdata;
  } vcc_parse_t;

  vcc_parse_t st_reg;
  vcc_parse_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.wr = 1'b0;
    st_next.rd = 1'b0;
    st_next.pwr_upd = 1'b0;
    if (valid_i) begin
      case (st_reg.state)
        VCC_ST_ADDR: begin
          st_next.pwr_upd = 1'b1;
          st_next.pwr = byte_i[ADDR_PWR_BIT];
          st_next.sel = byte_i[ADDR_SEL_MSB:ADDR_SEL_LSB];
          if (byte_i[ADDR_MORE_BIT]) begin
            if (byte_i[ADDR_RD_BIT]) begin
              st_next.rd = 1'b1;
            end else begin
              st_next.state = VCC_ST_DATA;
            end
          end
        end
        VCC_ST_DATA: begin
          st_next.wdata = byte_i;
          st_next.wr = 1'b1;
          st_next.state = VCC_ST_ADDR;
        end
        default: st_next.state = VCC_ST_ADDR;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '{state: VCC_ST_ADDR, wr: 1'b0, rd: 1'b0, pwr_upd: 1'b0,
                 pwr: PWR_RST, sel: 4'h0, wdata: REG_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign cmd.wr = st_reg.wr;
  assign cmd.rd = st_reg.rd;
  assign cmd.pwr_upd = st_reg.pwr_upd;
  assign cmd.pwr = st_reg.pwr;
  assign cmd.sel = st_reg.sel;
  assign cmd.wdata = st_reg.wdata;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_write_addr;
    valid_i && st_reg.state == VCC_ST_ADDR && byte_i[ADDR_MORE_BIT] && !byte_i[ADDR_RD_BIT];
  endsequence
  sequence s_read_addr;
    valid_i && st_reg.state == VCC_ST_ADDR && byte_i[ADDR_MORE_BIT] && byte_i[ADDR_RD_BIT];
  endsequence

  property p_read_cmd;
    s_read_addr |=> cmd.rd && !cmd.wr && st_reg.state == VCC_ST_ADDR;
  endproperty
  a_read_cmd: assert property (p_read_cmd) else $error("read command not issued");

  property p_write_pair;
    s_write_addr ##1 valid_i |=> cmd.wr && cmd.wdata == $past(byte_i);
  endproperty
  a_write_pair: assert property (p_write_pair) else $error("write pair lost");
endmodule

// *** tb/vcc_host_model.sv ***
/*
  Host controller model: sends address and data bytes to the register bank.
  Assumes the bench clock; drives on the falling edge, one byte per cycle.
*/
module vcc_host_model (
  input wire logic clk_i,
  output logic [7:0] byte_o,
  output logic valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    byte_o = 8'h00;
    valid_o = 1'b0;
  end
  // One byte; on release the line shows the inverse of the last byte
  task automatic send(input logic [7:0] b, input logic last);
    @(negedge clk_i);
    byte_o = b;
    valid_o = 1'b1;
    if (last) begin
      @(negedge clk_i);
      valid_o = 1'b0;
      byte_o = ~b;
    end
  endtask
  // Address byte then data byte
  task automatic wr(input logic [3:0] sel, input logic [7:0] d, input logic pd, input logic last);
    send({pd, sel, 3'b010}, 1'b0);
    send(d, last);
  endtask
  // Read-back address byte, no data follows
  task automatic rd(input logic [3:0] sel);
    send({1'b0, sel, 3'b110}, 1'b1);
  endtask
  // Single byte power control
  task automatic pwr(input logic pd);
    send({pd, 7'h00}, 1'b1);
  endtask
endmodule

// *** tb/tb_top.sv ***
/*
  Self-checking bench of the control register bank with a host model.
  Assumes a 50 MHz clock and PCM bytes given by the bench itself.
*/
module tb_top import vcc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn, sep, rxs, pdn, rvalid;
  logic [7:0] rxb, txp, rdata, rx_path, pcm_tx, cf, pc, ar, gn, v, b, d;
  wire [7:0] cmd_b;
  wire cmd_v;
  wire [32:0] cfg;
  logic [32:0] e;
  logic [7:0] exp_q[$];
  logic [3:0] rw_sel [4];
  int num_errors = 0;
  int num_checks = 0;
  int k;

  always #10 clk = ~clk;

  vcc_host_model i_vcc_host_model (.clk_i(clk), .byte_o(cmd_b), .valid_o(cmd_v));

  vcc_control_regs i_vcc_control_regs (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .CMD_BYTE_I(cmd_b), .CMD_VALID_I(cmd_v),
    .SEP_CTRL_MODE_I(sep), .PCM_RX_BYTE_I(rxb), .PCM_RX_STROBE_I(rxs),
    .TX_PATH_BYTE_I(txp), .RDATA_O(rdata), .RDATA_VALID_O(rvalid), .POWER_DOWN_O(pdn),
    .CLOCK_RATE_SEL_O(cfg[32:31]), .COMPANDING_LAW_SEL_O(cfg[30]),
    .CODING_VARIANT_SEL_O(cfg[29]), .PCM_TIMING_SEL_O(cfg[28]),
    .SLOT_SPACING_SEL_O(cfg[27]), .SLOT_WIDTH_SEL_O(cfg[26]), .LOOPBACK_SEL_O(cfg[25]),
    .HANDSFREE_PINS_EN_O(cfg[24]), .ANTI_FEEDBACK_EN_O(cfg[23]),
    .GENERAL_LATCH_OUT_O(cfg[22]), .GENERAL_LATCH_OE_O(cfg[21]),
    .RECEIVE_SOURCE_SEL_O(cfg[20]), .TRANSMIT_SOURCE_SEL_O(cfg[19]),
    .VOICE_XFER_EN_O(cfg[18]), .VOICE_CHANNEL_SEL_O(cfg[17:16]),
    .MICROPHONE_SEL_O(cfg[15]), .TRANSMIT_INPUT_EN_O(cfg[14]), .SIDETONE_EN_O(cfg[13]),
    .AUX_RING_ROUTE_EN_O(cfg[12]), .TONE_TO_SPEAKER_O(cfg[11]),
    .TONE_TO_EARPIECE_O(cfg[10]), .RX_TO_SPEAKER_O(cfg[9]), .RX_TO_EARPIECE_O(cfg[8]),
    .TX_GAIN_O(cfg[7:4]), .SIDETONE_GAIN_O(cfg[3:0]),
    .RX_PATH_BYTE_O(rx_path), .PCM_TX_BYTE_O(pcm_tx)
  );

  function automatic logic [32:0] exp_cfg(input logic s);
    return {s ? cf[7:6] : 2'h0, cf[5:4], cf[3] & s, cf[2] & s, cf[1:0],
            pc[7:6], 1'b0, pc[5], pc[4] & s, pc[3] & s, pc[2],
            s ? 2'h0 : pc[1:0], ar, gn};
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  // Write and update the shadow copy
  task automatic put(input logic [3:0] sel, input logic [7:0] val, input logic pd,
                     input logic last);
    i_vcc_host_model.wr(sel, val, pd, last);
    case (sel)
      SEL_CLOCK_FORMAT: cf = val;
      SEL_PATH_CHANNEL: pc = val;
      SEL_AUDIO_ROUTING: ar = val;
      SEL_GAIN: gn = val;
      default: ;
    endcase
  endtask

  task automatic get(input logic [3:0] sel, input logic [7:0] exp);
    exp_q.push_back(exp);
    i_vcc_host_model.rd(sel);
  endtask

  task automatic pcm_rx(input logic [7:0] val);
    @(negedge clk);
    rxb = val;
    rxs = 1'b1;
    @(negedge clk);
    rxs = 1'b0;
    rxb = ~val;
  endtask

  // Read answers taken in the middle of their one-cycle pulse
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("BAD %0t read answer not asked for", $time);
      end else begin
        check(33'(rdata), 33'(exp_q.pop_front()));
      end
    end
  end

  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(61275));
    rw_sel = '{SEL_CLOCK_FORMAT, SEL_PATH_CHANNEL, SEL_AUDIO_ROUTING, SEL_GAIN};
    {cf, pc, ar, gn} = 32'h0;
    rstn = 1'b0;
    sep = 1'b1;
    rxs = 1'b0;
    rxb = 8'h00;
    txp = 8'h00;
    repeat (3) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    repeat (6) @(negedge clk);
    check(cfg, exp_cfg(1'b1));
    check(33'({pdn, rx_path, pcm_tx}), 33'h0);
    $display("test reset done");
    // Every 2-bit code in every field, then random, each read back at once
    for (int i = 0; i < 24; i++) begin
      k = i / 4;
      v = (k < 4) ? {4{k[1:0]}} : 8'($urandom);
      put(rw_sel[i % 4], v, 1'b0, 1'b0);
      get(rw_sel[i % 4], v);
      settle();
      e = exp_cfg(1'b1);
      check(33'(cfg[32:16]), 33'(e[32:16]));
      check(33'(cfg[15:0]), 33'(e[15:0]));
    end
    $display("test fields done");
    sep = 1'b0;
    put(SEL_CLOCK_FORMAT, 8'hff, 1'b0, 1'b1);
    put(SEL_PATH_CHANNEL, 8'($urandom) | 8'h1b, 1'b0, 1'b1);
    repeat (6) @(negedge clk);
    check(cfg, exp_cfg(1'b0));
    get(SEL_CLOCK_FORMAT, 8'hff);
    sep = 1'b1;
    repeat (6) @(negedge clk);
    check(cfg, exp_cfg(1'b1));
    $display("test modes done");
    get(SEL_TRANSMIT_DATA, 8'h00);
    get(4'h7, 8'h00);
    put(4'h9, 8'hff, 1'b0, 1'b1);
    settle();
    check(cfg, exp_cfg(1'b1));
    $display("test refusals done");
    b = 8'($urandom);
    d = ~b ^ 8'h5a;
    put(SEL_PATH_CHANNEL, 8'h00, 1'b0, 1'b1);
    put(SEL_CLOCK_FORMAT, 8'h00, 1'b0, 1'b1);
    pcm_rx(b);
    settle();
    check(33'(rx_path), 33'(b));
    get(SEL_RECEIVE_DATA, b);
    put(SEL_RECEIVE_DATA, d, 1'b0, 1'b0);
    put(SEL_PATH_CHANNEL, 8'h10, 1'b0, 1'b1);
    settle();
    check(33'(rx_path), 33'(d));
    get(SEL_RECEIVE_DATA, b);
    put(SEL_TRANSMIT_DATA, d ^ 8'h33, 1'b0, 1'b0);
    put(SEL_PATH_CHANNEL, 8'h08, 1'b0, 1'b1);
    settle();
    check(33'(pcm_tx), 33'(d ^ 8'h33));
    get(SEL_TRANSMIT_DATA, 8'h00);
    put(SEL_PATH_CHANNEL, 8'h00, 1'b0, 1'b1);
    @(negedge clk) txp = 8'($urandom);
    settle();
    check(33'(pcm_tx), 33'(txp));
    put(SEL_CLOCK_FORMAT, 8'h01, 1'b0, 1'b1);
    settle();
    check(33'(pcm_tx), 33'(b));
    $display("test data paths done");
    put(SEL_GAIN, 8'ha5, 1'b1, 1'b1);
    settle();
    check(33'({pdn, cfg[7:0]}), 33'h1a5);
    i_vcc_host_model.pwr(1'b0);
    settle();
    check(33'({pdn, cfg[7:0]}), 33'h0a5);
    $display("test power done");
    @(negedge clk) rstn = 1'b0;
    {cf, pc, ar, gn} = 32'h0;
    @(negedge clk) rstn = 1'b1;
    repeat (2) @(negedge clk);
    check(cfg, exp_cfg(1'b1));
    check(33'({pdn, rx_path, pcm_tx}), 33'({9'h0, txp}));
    get(SEL_GAIN, 8'h00);
    $display("test second reset done");
    settle();
    check(33'(exp_q.size()), 33'h0);
    report_and_stop();
  end
endmodule
